/* File: common/timer_set_pkg.sv */
// Package with constants and carrier types for the cascaded timer set
package timer_set_pkg;
  localparam int T1_WIDTH = 10;
  localparam int T8_WIDTH = 8;
  localparam int FIX_WIDTH = 16;
  localparam int PRE_DIV_LO = 4;
  localparam int PRE_DIV_HI = 8;
  localparam logic [2:0] PRE_CNT_RST = 3'h0;
  localparam logic [9:0] T1_RST = 10'h000;
  localparam logic [7:0] T8_RST = 8'h00;
  localparam logic [15:0] FIX_RST = 16'h0000;
  localparam int WDT_BIT = 14;
  // Timer B source codes
  localparam logic [1:0] B_SRC_PRE = 2'h0;
  localparam logic [1:0] B_SRC_TA = 2'h1;
  localparam logic [1:0] B_SRC_ICLK = 2'h2;
  localparam logic [1:0] B_SRC_FIX = 2'h3;
  // Timer C source codes
  localparam logic [1:0] C_SRC_TB = 2'h0;
  localparam logic [1:0] C_SRC_PRE = 2'h1;
  localparam logic [1:0] C_SRC_OSC = 2'h2;

  // Control bits of prescaler and timer A
  typedef struct packed {
    logic prescale_run;
    logic prescale_ratio_sel;
    logic timer_a_source_sel;
    logic timer_a_run;
  } prescaler_timer_a_ctrl_t;

  // Control bits of timer B
  typedef struct packed {
    logic timer_b_run;
    logic square_out_en;
    logic timer_b_source_sel_hi;
    logic timer_b_source_sel_lo;
  } timer_b_ctrl_t;

  // Control bits of timer C
  typedef struct packed {
    logic timer_c_run;
    logic osc_half_sel;
    logic timer_c_source_sel_hi;
    logic timer_c_source_sel_lo;
  } timer_c_ctrl_t;

  // Software load strobes and values
  typedef struct packed {
    logic load_a;
    logic load_b;
    logic load_c;
    logic [9:0] value_a;
    logic [7:0] value_b;
    logic [7:0] value_c;
  } timer_load_t;
endpackage

/* File: src/cascaded_timer_set.sv */
// Cascaded timer set: prescaler, timers A, B, C and fixed 16-bit divider
//
// Behaviour
// - Programmable timers count down from n, underflow after n+1, flag, reload.
// - Fixed divider flags once every fixed number of count pulses.
// - Prescaler divides instruction clock by 4 or 8.
// - Prescaler pulse is a selectable source of all three timers.
// - Timer A is a 10-bit down counter, ratio 1 to 1024.
// - Timer A counts prescaler pulses or timer C underflow pulses.
// - Timer A underflow flags, gates carrier output, feeds timer B.
// - Timer B 8-bit, sources prescaler, A underflow, clock, fixed underflow.
// - Timer B underflow flags, feeds timer C, toggles square-wave pin.
// - Timer C 8-bit, sources B underflow, prescaler, oscillator or half.
// - Timer C underflow flags, forms carrier, feeds timer A.
// - Fixed 16-bit divider runs freely with no control.
// - Three control words start, stop and configure prescaler and timers.
// - Ratio bit 0 selects /4, 1 selects /8; run low clears prescaler.
// - Timer A source bit 0 prescaler, 1 timer C underflow.
// - Timer B codes 00 pre, 01 A underflow, 10 clock, 11 fixed.
// - Timer C codes 00 B underflow, 01 pre, 10 oscillator; 11 none.
`timescale 1ns/1ps
module cascaded_timer_set
  import timer_set_pkg::*;
#(
  parameter int A_WIDTH = T1_WIDTH,
  parameter int B_WIDTH = T8_WIDTH
) (
  input wire logic clk_sys_in, // System clock
  input wire logic rstn_in, // Synchronous reset, active low
  input wire logic iclk_pulse_in, // Instruction clock tick
  input wire logic osc_pulse_in, // Oscillator tick
  input wire timer_set_pkg::prescaler_timer_a_ctrl_t ctrl_a_in, // Word 1
  input wire timer_set_pkg::timer_b_ctrl_t ctrl_b_in, // Word 2
  input wire timer_set_pkg::timer_c_ctrl_t ctrl_c_in, // Word 3
  input wire timer_set_pkg::timer_load_t load_in, // Load strobes
  input wire logic clear_flags_in, // Clear all request flags
  input wire logic carrier_en_in, // Carrier enable
  output logic [9:0] count_a_out, // Timer A count
  output logic [7:0] count_b_out, // Timer B count
  output logic [7:0] count_c_out, // Timer C count
  output logic flag_a_out, // Timer A request
  output logic flag_b_out, // Timer B request
  output logic flag_c_out, // Timer C request
  output logic flag_fix_out, // Fixed divider request
  output logic prescaler_out_pulse, // Prescaler pulse
  output logic carrier_out, // Carrier wave output
  output logic square_out, // Square-wave pin
  output logic wdt_tick_out // Watchdog count pulse
);
  import timer_set_pkg::*;

  logic [2:0] pre_cnt_q, pre_cnt_d;
  logic pre_pulse_q, pre_pulse_d;
  logic [9:0] a_cnt_q, a_cnt_d, a_rld_q, a_rld_d;
  logic [7:0] b_cnt_q, b_cnt_d, b_rld_q, b_rld_d;
  logic [7:0] c_cnt_q, c_cnt_d, c_rld_q, c_rld_d;
  logic [15:0] fix_q, fix_d;
  logic osc_half_q, osc_half_d;
  logic ua_q, ua_d, ub_q, ub_d, uc_q, uc_d, uf_q, uf_d;
  logic fa_q, fa_d, fb_q, fb_d, fc_q, fc_d, ff_q, ff_d;
  logic car_q, car_d, sq_q, sq_d, gate_q, gate_d, wdt_q, wdt_d;
  logic en_a, en_b, en_c;

  // Next value of a down counter with auto reload
  function automatic logic [9:0] count_next(input logic [9:0] cnt,
                                            input logic [9:0] rld,
                                            input logic en);
    if (!en) begin
      count_next = cnt;
    end else if (cnt == 10'h000) begin
      count_next = rld;
    end else begin
      count_next = cnt - 10'h001;
    end
  endfunction

  // Flag set wins over software clear
  function automatic logic flag_next(input logic f, input logic set,
                                     input logic clr);
    flag_next = set | (f & ~clr);
  endfunction

  // Count enables from selected sources, each a one-cycle pulse
  always_comb begin
    en_a = 1'b0;
    en_b = 1'b0;
    en_c = 1'b0;
    if (ctrl_a_in.timer_a_run) begin
      en_a = ctrl_a_in.timer_a_source_sel ? uc_q : pre_pulse_q;
    end
    if (ctrl_b_in.timer_b_run) begin
      case ({ctrl_b_in.timer_b_source_sel_hi,
             ctrl_b_in.timer_b_source_sel_lo})
        B_SRC_PRE: en_b = pre_pulse_q;
        B_SRC_TA: en_b = ua_q;
        B_SRC_ICLK: en_b = iclk_pulse_in;
        B_SRC_FIX: en_b = uf_q;
        default: en_b = 1'b0;
      endcase
    end
    if (ctrl_c_in.timer_c_run) begin
      case ({ctrl_c_in.timer_c_source_sel_hi,
             ctrl_c_in.timer_c_source_sel_lo})
        C_SRC_TB: en_c = ub_q;
        C_SRC_PRE: en_c = pre_pulse_q;
        C_SRC_OSC: en_c = ctrl_c_in.osc_half_sel ?
                          (osc_pulse_in & osc_half_q) : osc_pulse_in;
        default: en_c = 1'b0;
      endcase
    end
  end

  // Prescaler and fixed divider next state
  always_comb begin
    pre_cnt_d = pre_cnt_q;
    pre_pulse_d = 1'b0;
    fix_d = fix_q;
    uf_d = 1'b0;
    wdt_d = 1'b0;
    osc_half_d = osc_half_q ^ osc_pulse_in;
    if (!ctrl_a_in.prescale_run) begin
      pre_cnt_d = PRE_CNT_RST;
    end else if (iclk_pulse_in) begin
      if (pre_cnt_q == (ctrl_a_in.prescale_ratio_sel ?
                        3'(PRE_DIV_HI - 1) : 3'(PRE_DIV_LO - 1))) begin
        pre_cnt_d = PRE_CNT_RST;
        pre_pulse_d = 1'b1;
      end else begin
        pre_cnt_d = pre_cnt_q + 3'h1;
      end
    end
    if (iclk_pulse_in) begin
      fix_d = fix_q - 16'h0001;
      uf_d = (fix_q == FIX_RST);
      wdt_d = fix_q[WDT_BIT] & ~fix_d[WDT_BIT];
    end
  end

  // Programmable timers, flags and output waveforms next state
  always_comb begin
    a_rld_d = load_in.load_a ? load_in.value_a : a_rld_q;
    b_rld_d = load_in.load_b ? load_in.value_b : b_rld_q;
    c_rld_d = load_in.load_c ? load_in.value_c : c_rld_q;
    a_cnt_d = load_in.load_a ? load_in.value_a :
              count_next(a_cnt_q, a_rld_q, en_a);
    b_cnt_d = load_in.load_b ? load_in.value_b :
              8'(count_next({2'h0, b_cnt_q}, {2'h0, b_rld_q}, en_b));
    c_cnt_d = load_in.load_c ? load_in.value_c :
              8'(count_next({2'h0, c_cnt_q}, {2'h0, c_rld_q}, en_c));
    ua_d = en_a & (a_cnt_q == T1_RST);
    ub_d = en_b & (b_cnt_q == T8_RST);
    uc_d = en_c & (c_cnt_q == T8_RST);
    fa_d = flag_next(fa_q, ua_d, clear_flags_in);
    fb_d = flag_next(fb_q, ub_d, clear_flags_in);
    fc_d = flag_next(fc_q, uc_d, clear_flags_in);
    ff_d = flag_next(ff_q, uf_d, clear_flags_in);
    car_d = uc_d ? ~car_q : car_q;
    sq_d = (ub_d & ctrl_b_in.square_out_en) ? ~sq_q : sq_q;
    gate_d = ua_d ? ~gate_q : gate_q;
  end

  // Register all state
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      pre_cnt_q <= PRE_CNT_RST;
      pre_pulse_q <= 1'b0;
      a_cnt_q <= T1_RST;
      a_rld_q <= T1_RST;
      b_cnt_q <= T8_RST;
      b_rld_q <= T8_RST;
      c_cnt_q <= T8_RST;
      c_rld_q <= T8_RST;
      fix_q <= FIX_RST;
      osc_half_q <= 1'b0;
      ua_q <= 1'b0;
      ub_q <= 1'b0;
      uc_q <= 1'b0;
      uf_q <= 1'b0;
      fa_q <= 1'b0;
      fb_q <= 1'b0;
      fc_q <= 1'b0;
      ff_q <= 1'b0;
      car_q <= 1'b0;
      sq_q <= 1'b0;
      gate_q <= 1'b0;
      wdt_q <= 1'b0;
    end else begin
      pre_cnt_q <= pre_cnt_d;
      pre_pulse_q <= pre_pulse_d;
      a_cnt_q <= a_cnt_d;
      a_rld_q <= a_rld_d;
      b_cnt_q <= b_cnt_d;
      b_rld_q <= b_rld_d;
      c_cnt_q <= c_cnt_d;
      c_rld_q <= c_rld_d;
      fix_q <= fix_d;
      osc_half_q <= osc_half_d;
      ua_q <= ua_d;
      ub_q <= ub_d;
      uc_q <= uc_d;
      uf_q <= uf_d;
      fa_q <= fa_d;
      fb_q <= fb_d;
      fc_q <= fc_d;
      ff_q <= ff_d;
      car_q <= car_d;
      sq_q <= sq_d;
      gate_q <= gate_d;
      wdt_q <= wdt_d;
    end
  end

  // Outputs straight from flip-flops
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      carrier_out <= 1'b0;
    end else begin
      carrier_out <= car_d & carrier_en_in & (gate_d | ~ctrl_a_in.timer_a_run);
    end
  end

  assign count_a_out = a_cnt_q;
  assign count_b_out = b_cnt_q;
  assign count_c_out = c_cnt_q;
  assign flag_a_out = fa_q;
  assign flag_b_out = fb_q;
  assign flag_c_out = fc_q;
  assign flag_fix_out = ff_q;
  assign prescaler_out_pulse = pre_pulse_q;
  assign square_out = sq_q;
  assign wdt_tick_out = wdt_q;
endmodule

/* File: testbench/timer_set_checker.sv */
// Assertion checker bound to the cascaded timer set
`timescale 1ns/1ps
module timer_set_checker
  import timer_set_pkg::*;
(
  input wire logic clk_sys_in, // Clock
  input wire logic rstn_in, // Reset
  input wire logic iclk_pulse_in, // Tick
  input wire timer_set_pkg::prescaler_timer_a_ctrl_t ctrl_a_in, // Word 1
  input wire timer_set_pkg::timer_b_ctrl_t ctrl_b_in, // Word 2
  input wire timer_set_pkg::timer_c_ctrl_t ctrl_c_in, // Word 3
  input wire timer_set_pkg::timer_load_t load_in, // Loads
  input wire logic clear_flags_in, // Clear
  input wire logic [7:0] count_b_out, // Count B
  input wire logic [7:0] count_c_out, // Count C
  input wire logic flag_a_out, // Flag A
  input wire logic flag_b_out, // Flag B
  input wire logic prescaler_out_pulse // Prescaler
);
  default clocking dc @(posedge clk_sys_in);
  endclocking
  default disable iff (!rstn_in);
  logic b_en;
  // Timer B counting instruction clock ticks
  assign b_en = ctrl_b_in.timer_b_run && iclk_pulse_in && !load_in.load_b &&
    {ctrl_b_in.timer_b_source_sel_hi, ctrl_b_in.timer_b_source_sel_lo}
    == B_SRC_ICLK;
  // Quiet spans after a prescaler pulse
  sequence quiet4;
    !prescaler_out_pulse [*3];
  endsequence
  sequence quiet8;
    !prescaler_out_pulse [*7];
  endsequence
  AST_PRE_DIV4: assert property (
    prescaler_out_pulse && !ctrl_a_in.prescale_ratio_sel |=> quiet4)
    else $error("Prescaler pulses too close at ratio 4");
  AST_PRE_DIV8: assert property (
    prescaler_out_pulse && ctrl_a_in.prescale_ratio_sel |=> quiet8)
    else $error("Prescaler pulses too close at ratio 8");
  AST_PRE_STOP: assert property (
    !ctrl_a_in.prescale_run ##1 !ctrl_a_in.prescale_run |->
    !prescaler_out_pulse) else $error("Stopped prescaler pulsed");
  AST_B_HOLD: assert property (
    !ctrl_b_in.timer_b_run && !load_in.load_b |=> $stable(count_b_out))
    else $error("Stopped timer B changed");
  AST_C_NONE: assert property (
    ctrl_c_in.timer_c_source_sel_hi && ctrl_c_in.timer_c_source_sel_lo &&
    !load_in.load_c |=> $stable(count_c_out))
    else $error("Timer C counted with no source");
  AST_FLAG_STICK: assert property (
    flag_a_out && !clear_flags_in |=> flag_a_out)
    else $error("Timer A flag dropped");
  AST_B_DEC: assert property (
    b_en && count_b_out != 8'h00 |=>
    count_b_out == $past(count_b_out) - 8'h01)
    else $error("Timer B did not count down");
  AST_B_UF: assert property (
    b_en && count_b_out == 8'h00 |=> flag_b_out)
    else $error("Timer B underflow without flag");
  AST_LOAD_B: assert property (
    load_in.load_b |=> count_b_out == $past(load_in.value_b))
    else $error("Timer B load lost");
endmodule
bind cascaded_timer_set timer_set_checker i_chk (
  .clk_sys_in, .rstn_in, .iclk_pulse_in, .ctrl_a_in, .ctrl_b_in,
  .ctrl_c_in, .load_in, .clear_flags_in, .count_b_out, .count_c_out,
  .flag_a_out, .flag_b_out, .prescaler_out_pulse);

/* File: testbench/tb_top.sv */
// Self-checking bench for the cascaded timer set
`timescale 1ns/1ps
module tb_top;
  import timer_set_pkg::*;
  `define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin \
    miscompares++; $display("MISMATCH t=%0t %h %h", $time, a, e); end end
  logic clk_sys_in = 0, rstn_in = 0, clear_flags_in = 0;
  prescaler_timer_a_ctrl_t ca = '0;
  timer_b_ctrl_t cb = '0;
  timer_c_ctrl_t cc = '0;
  timer_load_t ld = '0;
  logic [7:0] cnt_c;
  logic fa, fb, fc, ffix, pre, sq, wdt;
  int miscompares = 0, n_compared = 0, wdt_n = 0, cyc = 0;
  // Row table: ratio, sources, loads, window and expected counts
  int rt[6] = '{0, 1, 0, 0, 0, 0};
  int bs[6] = '{2, 0, 1, 3, 2, 1};
  int bv[6] = '{5, 2, 0, 0, 255, 0};
  int av[6] = '{1, 1, 1, 1, 1, 1023};
  int cs[6] = '{0, 1, 2, 3, 0, 0};
  int wn[6] = '{120, 96, 121, 120, 512, 8194};
  int tw[6] = '{20, 4, 15, 0, 2, 2};
  int cw[6] = '{60, 48, 60, 0, 256, 4096};
  int pw[6] = '{30, 12, 30, 30, 128, 2048};
  cascaded_timer_set i_dut (
    .clk_sys_in, .rstn_in, .iclk_pulse_in(1'b1), .osc_pulse_in(1'b1),
    .ctrl_a_in(ca), .ctrl_b_in(cb), .ctrl_c_in(cc), .load_in(ld),
    .clear_flags_in, .carrier_en_in(1'b1), .count_a_out(),
    .count_b_out(), .count_c_out(cnt_c), .flag_a_out(fa),
    .flag_b_out(fb), .flag_c_out(fc), .flag_fix_out(ffix),
    .prescaler_out_pulse(pre), .carrier_out(), .square_out(sq),
    .wdt_tick_out(wdt));
  // Clock
  initial begin
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  // Cycles and watchdog ticks since reset release
  always @(posedge clk_sys_in) begin
    if (rstn_in) begin
      cyc <= cyc + 1;
      wdt_n <= wdt_n + int'(wdt);
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Stop, reload, restart and count events over one window
  task automatic run_row(input int r);
    int tg = 0, cz = 0, np = 0;
    logic sp;
    tick(1);
    ca <= {1'b0, ca.prescale_ratio_sel, 2'b00};
    cb <= '0;
    cc <= '0;
    tick(10);
    ca <= {1'b0, 1'(rt[r]), 2'b00};
    cb <= {2'b01, 2'(bs[r])};
    cc <= {2'b00, 2'(cs[r])};
    ld <= {3'b111, 10'(av[r]), 8'(bv[r]), 8'h01};
    tick(1);
    ld <= '0;
    ca <= {1'b1, 1'(rt[r]), 2'b01};
    cb <= {2'b11, 2'(bs[r])};
    cc <= {2'b10, 2'(cs[r])};
    clear_flags_in <= 1'b1;
    tick(1);
    clear_flags_in <= 1'b0;
    #1 sp = sq;
    for (int i = 0; i < wn[r]; i++) begin
      tick(1);
      #1;
      tg += int'(sq !== sp);
      sp = sq;
      cz += int'(cnt_c === 8'h00);
      np += int'(pre === 1'b1);
    end
    `CHK(tg, tw[r])
    `CHK(cz, cw[r])
    `CHK(np, pw[r])
    `CHK(fb, 1'(tw[r] != 0))
    `CHK(fc, 1'(cw[r] != 0))
    `CHK(fa, 1'b1)
  endtask
  // Main sequence
  initial begin
    tick(12);
    rstn_in <= 1'b1;
    for (int r = 0; r < 6; r++) run_row(r);
    tick(1);
    clear_flags_in <= 1'b1;
    tick(1);
    clear_flags_in <= 1'b0;
    for (int i = 0; i < 70000 && ffix !== 1'b1; i++) begin
      tick(1);
      #1;
    end
    `CHK(ffix, 1'b1)
    `CHK(1'(cyc inside {[65536:65540]}), 1'b1)
    `CHK(wdt_n, 2)
    report_and_stop();
  end
  // Watchdog against a hang
  initial begin
    tick(90000);
    miscompares++;
    report_and_stop();
  end
endmodule
